// *** verilog/adcp_pkg.sv ***
// Shared constants and types of the converter sample packetiser.
// Assumes an APB master with 32-bit data and an 8-bit byte address.
package adcp_pkg;
  localparam int NPIN = 8;
  localparam int PIN_W = 3;
  localparam int SMP_W = 12;
  localparam int DEST_W = 24;
  localparam int FIFO_W = PIN_W + SMP_W;
  localparam int FIFO_D = 4;
  // Register map, byte addresses
  localparam logic [7:0] OFF_PIN0 = 8'h00;
  localparam logic [7:0] OFF_PIN7 = 8'h1c;
  localparam logic [7:0] OFF_GEN = 8'h20;
  // Field positions
  localparam int PIN_EN_B = 0;
  localparam int PIN_DEST_LSB = 8;
  localparam int GEN_EN_B = 0;
  localparam int GEN_CAL_B = 1;
  localparam int GEN_SPP_LSB = 8;
  localparam int GEN_WID_LSB = 16;
  localparam int GEN_DROP_B = 24;
  // Reset values
  localparam logic [1:0] WID_RST = 2'h1;
  localparam logic [7:0] SPP_RST = 8'h01;
  localparam logic DROP_RST = 1'h1;
  // Sample width codes; code equals bytes per sample minus one
  localparam logic [1:0] WID_8 = 2'h0;
  localparam logic [1:0] WID_16 = 2'h1;
  localparam logic [1:0] WID_RSV = 2'h2;
  localparam logic [1:0] WID_32 = 2'h3;
  localparam logic [2:0] CAL_PULSES = 3'h6;
  localparam logic [2:0] LAST_PIN = 3'h7;
  localparam logic [7:0] END_TOKEN = 8'h01;
  localparam int PAD_W = 32 - SMP_W;

  typedef enum logic [3:0] {
    CV_IDLE = 4'h1,
    CV_SCAN = 4'h2,
    CV_WAIT = 4'h4,
    CV_PUSH = 4'h8
  } adcp_cv_e;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_DATA = 4'h2,
    TX_END = 4'h4,
    TX_FLUSH = 4'h8
  } adcp_tx_e;
endpackage : adcp_pkg

// *** verilog/adcp_fifo.sv ***
// Small synchronous FIFO between conversion and packet output.
// Assumes one clock; ce low freezes it.
`timescale 1ns/100ps
module adcp_fifo #(
  parameter int W = 15,
  parameter int D = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  localparam int CW = $clog2(D + 1);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } adcp_fifo_s;
  adcp_fifo_s r;
  adcp_fifo_s n;
  logic push;
  logic pop;

  assign in_ready = (r.cnt != CW'(D));
  assign out_valid = (r.cnt != '0);
  assign out_data = r.mem[r.rp];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb
  begin
    n = r;
    if (push)
    begin
      n.mem[r.wp] = in_data;
      n.wp = (r.wp == AW'(D - 1)) ? '0 : r.wp + AW'(1);
    end
    if (pop)
      n.rp = (r.rp == AW'(D - 1)) ? '0 : r.rp + AW'(1);
    if (push & ~pop)
      n.cnt = r.cnt + CW'(1);
    else if (pop & ~push)
      n.cnt = r.cnt - CW'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r <= '0;
    else if (ce)
      r <= n;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_full_stalls;
    (r.cnt == CW'(D)) |-> !in_ready;
  endproperty
  a_full_stalls: assert property (p_full_stalls)
    else $error("fifo accepts while full");

  property p_count_track;
    (ce && push && !pop) |=> (r.cnt == $past(r.cnt) + CW'(1));
  endproperty
  a_count_track: assert property (p_count_track)
    else $error("fifo count not advanced on push");
endmodule : adcp_fifo

// *** verilog/adcp_ctrl.sv ***
// Converter control and sample packetiser with APB register access.
// Assumes a converter that answers conv_req with a conv_done pulse and
// a network sink that takes a byte when tx_valid and tx_ready are high.
//
// Contract
// - Each pin register holds the 24-bit destination in bits 31:8.
// - Pin register bit 0 enables the pin, resets to 0; bits 7:1 read zero.
// - Eight pin registers sit at byte offsets 0x00 to 0x1c.
// - A lost sample sets general bit 24, which a read of it clears.
// - Bits 17:16 pick the sample width, reset 1, code 2 is reserved.
// - Width 1 sends a left-aligned 16-bit sample, high byte first.
// - Width 3 sends a 32-bit word with low 20 bits zero, MSB first.
// - Bits 15:8 set samples per packet, reset 1; 0 closes on access.
// - General bit 1 selects the internal calibration reference.
// - While general bit 0 is set, pin registers ignore writes.
// - The first six triggers after enable only calibrate.
// - Those six calibration triggers recur on every enable 0 to 1.
`timescale 1ns/100ps
module adcp_ctrl
  import adcp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic smp_trig,
  output logic conv_req,
  output logic [PIN_W-1:0] conv_pin,
  output logic conv_cal_sel,
  output logic cal_pulse,
  input wire logic conv_done,
  input wire logic [SMP_W-1:0] conv_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [7:0] tx_data,
  output logic tx_ctrl,
  output logic [DEST_W-1:0] tx_dest
);
  typedef struct packed {
    logic [NPIN-1:0][DEST_W-1:0] dest;
    logic [NPIN-1:0] pen;
    logic gen_en;
    logic gen_cal;
    logic [7:0] spp;
    logic [1:0] wid;
    logic drop;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [2:0] calc;
    adcp_cv_e cv;
    logic [PIN_W-1:0] scan;
    logic conv_req;
    logic cal_pulse;
    logic [SMP_W-1:0] smp;
    adcp_tx_e tx;
    logic [31:0] word;
    logic [1:0] left;
    logic [PIN_W-1:0] tpin;
    logic [NPIN-1:0][7:0] cnt;
    logic [NPIN-1:0] open;
    logic flush;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_ctrl;
    logic [DEST_W-1:0] tx_dest;
  } adcp_st_s;

  adcp_st_s r;
  adcp_st_s n;
  logic acc;
  logic done;
  logic f_in_ready;
  logic f_out_valid;
  logic f_out_ready;
  logic [FIFO_W-1:0] f_out_data;
  logic [7:0] cnt_inc;

  function automatic logic is_pin(input logic [7:0] a);
    return (a >= OFF_PIN0) && (a <= OFF_PIN7) && (a[1:0] == 2'h0);
  endfunction : is_pin

  function automatic logic is_gen(input logic [7:0] a);
    return a == OFF_GEN;
  endfunction : is_gen

  assign acc = psel & penable;
  assign done = acc & r.pready;

  adcp_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .in_valid(r.cv == CV_PUSH),
    .in_ready(f_in_ready),
    .in_data({r.scan, r.smp}),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out_data)
  );

  // Flush has priority so a closing access is not overtaken by data
  assign f_out_ready = (r.tx == TX_IDLE) & ~r.flush;

  always_comb
  begin
    n = r;
    cnt_inc = r.cnt[r.tpin] + 8'h01;
    n.cal_pulse = 1'b0;
    n.pready = acc & ~r.pready;

    // Read data is captured on the same edge that raises pready
    if (acc & ~r.pready)
    begin
      n.pslverr = ~(is_pin(paddr) | is_gen(paddr));
      n.prdata = '0;
      if (is_pin(paddr))
      begin
        n.prdata[31:PIN_DEST_LSB] = r.dest[paddr[4:2]];
        n.prdata[PIN_EN_B] = r.pen[paddr[4:2]];
      end
      else if (is_gen(paddr))
      begin
        n.prdata[GEN_DROP_B] = r.drop;
        n.prdata[GEN_WID_LSB +: 2] = r.wid;
        n.prdata[GEN_SPP_LSB +: 8] = r.spp;
        n.prdata[GEN_CAL_B] = r.gen_cal;
        n.prdata[GEN_EN_B] = r.gen_en;
      end
    end

    if (done & pwrite & is_pin(paddr) & ~r.gen_en)
    begin
      n.dest[paddr[4:2]] = pwdata[31:PIN_DEST_LSB];
      n.pen[paddr[4:2]] = pwdata[PIN_EN_B];
    end
    if (done & pwrite & is_gen(paddr))
    begin
      n.gen_en = pwdata[GEN_EN_B];
      if (pwdata[GEN_EN_B] & ~r.gen_en)
        n.calc = '0;
      n.gen_cal = pwdata[GEN_CAL_B];
      n.spp = pwdata[GEN_SPP_LSB +: 8];
      // Reserved width code leaves the field unchanged
      if (pwdata[GEN_WID_LSB +: 2] != WID_RSV)
        n.wid = pwdata[GEN_WID_LSB +: 2];
    end
    if (done & ~pwrite & is_gen(paddr))
      n.drop = 1'b0;

    // Conversion side
    unique case (r.cv)
      CV_IDLE:
      begin
        if (r.gen_en & smp_trig)
        begin
          if (r.calc < CAL_PULSES)
          begin
            n.calc = r.calc + 3'h1;
            n.cal_pulse = 1'b1;
          end
          else
          begin
            n.scan = '0;
            n.cv = CV_SCAN;
          end
        end
      end
      CV_SCAN:
      begin
        if (r.pen[r.scan])
        begin
          n.conv_req = 1'b1;
          n.cv = CV_WAIT;
        end
        else if (r.scan == LAST_PIN)
          n.cv = CV_IDLE;
        else
          n.scan = r.scan + 3'h1;
      end
      CV_WAIT:
      begin
        if (conv_done)
        begin
          n.conv_req = 1'b0;
          n.smp = conv_data;
          n.cv = CV_PUSH;
        end
      end
      CV_PUSH:
      begin
        // A full FIFO holds the scan here, so triggers meanwhile are lost
        if (f_in_ready)
        begin
          if (r.scan == LAST_PIN)
            n.cv = CV_IDLE;
          else
          begin
            n.scan = r.scan + 3'h1;
            n.cv = CV_SCAN;
          end
        end
      end
    endcase

    // Packet side
    unique case (r.tx)
      TX_IDLE:
      begin
        if (r.flush)
        begin
          n.flush = 1'b0;
          n.tpin = '0;
          n.tx = TX_FLUSH;
        end
        else if (f_out_valid)
        begin
          n.tpin = f_out_data[FIFO_W-1 -: PIN_W];
          // Sample is left aligned; width code gives bytes minus one
          n.word = {f_out_data[SMP_W-1:0], PAD_W'(0)};
          n.left = r.wid;
          n.tx_valid = 1'b1;
          n.tx_ctrl = 1'b0;
          n.tx_data = f_out_data[SMP_W-1 -: 8];
          n.tx_dest = r.dest[f_out_data[FIFO_W-1 -: PIN_W]];
          n.word = {f_out_data[SMP_W-9:0], PAD_W'(0), 8'h00};
          n.tx = TX_DATA;
        end
      end
      TX_DATA:
      begin
        if (tx_ready)
        begin
          if (r.left != 2'h0)
          begin
            n.tx_data = r.word[31:24];
            n.word = {r.word[23:0], 8'h00};
            n.left = r.left - 2'h1;
          end
          else if ((r.spp != 8'h00) && (cnt_inc >= r.spp))
          begin
            n.cnt[r.tpin] = 8'h00;
            n.open[r.tpin] = 1'b0;
            n.tx_ctrl = 1'b1;
            n.tx_data = END_TOKEN;
            n.tx = TX_END;
          end
          else
          begin
            n.cnt[r.tpin] = cnt_inc;
            n.open[r.tpin] = 1'b1;
            n.tx_valid = 1'b0;
            n.tx = TX_IDLE;
          end
        end
      end
      TX_END:
      begin
        if (tx_ready)
        begin
          n.tx_valid = 1'b0;
          n.tx_ctrl = 1'b0;
          n.tx = TX_IDLE;
        end
      end
      TX_FLUSH:
      begin
        if (r.tx_valid)
        begin
          if (tx_ready)
          begin
            n.tx_valid = 1'b0;
            n.tx_ctrl = 1'b0;
            n.open[r.tpin] = 1'b0;
            n.cnt[r.tpin] = 8'h00;
          end
        end
        else if (r.open[r.tpin])
        begin
          n.tx_valid = 1'b1;
          n.tx_ctrl = 1'b1;
          n.tx_data = END_TOKEN;
          n.tx_dest = r.dest[r.tpin];
        end
        else if (r.tpin == LAST_PIN)
          n.tx = TX_IDLE;
        else
          n.tpin = r.tpin + 3'h1;
      end
    endcase

    // Set after clear so a coinciding event wins
    if (done & (is_pin(paddr) | is_gen(paddr)) & (r.spp == 8'h00))
      n.flush = 1'b1;
    if (r.gen_en & smp_trig & (r.calc >= CAL_PULSES) & (r.cv != CV_IDLE))
      n.drop = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r <= '0;
      r.wid <= WID_RST;
      r.spp <= SPP_RST;
      r.drop <= DROP_RST;
      r.cv <= CV_IDLE;
      r.tx <= TX_IDLE;
    end
    else if (ce)
      r <= n;
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign conv_req = r.conv_req;
  assign conv_pin = r.scan;
  assign conv_cal_sel = r.gen_cal;
  assign cal_pulse = r.cal_pulse;
  assign tx_valid = r.tx_valid;
  assign tx_data = r.tx_data;
  assign tx_ctrl = r.tx_ctrl;
  assign tx_dest = r.tx_dest;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_locked_pin_write;
    ce && done && pwrite && is_pin(paddr) && r.gen_en;
  endsequence

  property p_pin_lock;
    s_locked_pin_write |=> (r.dest == $past(r.dest)) && (r.pen == $past(r.pen));
  endproperty
  a_pin_lock: assert property (p_pin_lock)
    else $error("pin register changed while enabled");

  property p_cal_quiet;
    (ce && r.cv == CV_IDLE && r.gen_en && smp_trig && r.calc < CAL_PULSES)
      |=> cal_pulse && !conv_req && (r.cv == CV_IDLE);
  endproperty
  a_cal_quiet: assert property (p_cal_quiet)
    else $error("conversion started during calibration");

  property p_enable_rearm;
    (ce && !r.gen_en) ##1 (ce && r.gen_en) |-> (r.calc == 3'h0) || $past(smp_trig);
  endproperty
  a_enable_rearm: assert property (p_enable_rearm)
    else $error("calibration count not restarted on enable");

  property p_drop_clear;
    (ce && done && !pwrite && is_gen(paddr) && !smp_trig) |=> !r.drop;
  endproperty
  a_drop_clear: assert property (p_drop_clear)
    else $error("dropped flag survived a read");

  property p_drop_set;
    (ce && r.gen_en && smp_trig && r.calc >= CAL_PULSES && r.cv != CV_IDLE) |=> r.drop;
  endproperty
  a_drop_set: assert property (p_drop_set)
    else $error("lost sample not flagged");

  property p_wid_legal;
    r.wid != WID_RSV;
  endproperty
  a_wid_legal: assert property (p_wid_legal)
    else $error("reserved width code stored");

  property p_reserved_zero;
    (pready && is_pin(paddr) && !pwrite) |-> (prdata[7:1] == 7'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("pin register reserved bits not zero");

  sequence s_last_byte;
    ce && r.tx == TX_DATA && tx_ready && r.left == 2'h0 && r.spp != 8'h00
      && cnt_inc >= r.spp;
  endsequence

  property p_pkt_close;
    s_last_byte |=> tx_valid && tx_ctrl && (tx_data == END_TOKEN);
  endproperty
  a_pkt_close: assert property (p_pkt_close)
    else $error("packet not closed at sample count");

  property p_conv_enabled;
    conv_req |-> r.pen[conv_pin];
  endproperty
  a_conv_enabled: assert property (p_conv_enabled)
    else $error("conversion of a disabled pin");
endmodule : adcp_ctrl

// *** verification/adcp_far_model.sv ***
// Converter and network sink models on the far side of the packetiser.
// Assumes the bench seeds $urandom and supplies the sample base value.
`timescale 1ns/100ps
module adcp_far_model
  import adcp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic conv_req,
  input wire logic [PIN_W-1:0] conv_pin,
  input wire logic [SMP_W-1:0] smp_base,
  input wire logic hold_tx,
  output logic conv_done,
  output logic [SMP_W-1:0] conv_data,
  output logic tx_ready
);
  logic busy;
  logic [2:0] wait_cnt;
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy <= 1'b0;
      wait_cnt <= 3'h0;
      conv_done <= 1'b0;
      conv_data <= '0;
      tx_ready <= 1'b0;
    end
    else
    begin
      tx_ready <= !hold_tx && ($urandom % 4 != 0);
      conv_done <= 1'b0;
      // Data is only meaningful in the done cycle
      conv_data <= ~conv_data;
      if (!conv_req)
        busy <= 1'b0;
      else if (!busy)
      begin
        busy <= 1'b1;
        wait_cnt <= 3'($urandom % 4);
      end
      else if (wait_cnt == 3'h0)
      begin
        conv_done <= 1'b1;
        conv_data <= smp_base + 12'(13 * conv_pin);
        wait_cnt <= 3'h7;
      end
      else if (wait_cnt != 3'h7)
        wait_cnt <= wait_cnt - 3'h1;
    end
  end
endmodule : adcp_far_model

// *** verification/adcp_ctrl_bench.sv ***
// Self-checking bench for the packetiser: APB master, trigger source.
// Assumes adcp_far_model as converter and sink; expectations in queues.
`timescale 1ns/100ps
module adcp_ctrl_bench
  import adcp_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic smp_trig = 1'b0;
  logic hold_tx = 1'b0;
  logic ce = 1'b1;
  int v_conv = 0;
  logic [SMP_W-1:0] smp_base = '0;
  logic [31:0] prdata;
  logic pready, pslverr, conv_req, conv_cal_sel, cal_pulse, conv_done;
  logic tx_valid, tx_ready, tx_ctrl;
  logic [PIN_W-1:0] conv_pin;
  logic [SMP_W-1:0] conv_data;
  logic [7:0] tx_data;
  logic [DEST_W-1:0] tx_dest;
  int mismatches = 0;
  int comparisons = 0;
  int cal_seen = 0;
  int conv_seen = 0;
  int cnt[NPIN];
  logic [33:0] rq[$];
  logic [32:0] tq[$];
  logic [33:0] e;
  logic [31:0] pin_reg[NPIN];
  logic [7:0] mask;
  logic [1:0] wid = WID_16;
  logic [7:0] spp = 8'h01;
  logic [31:0] seed_v;

  adcp_ctrl adcp_ctrl_inst (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .smp_trig(smp_trig), .conv_req(conv_req),
    .conv_pin(conv_pin), .conv_cal_sel(conv_cal_sel), .cal_pulse(cal_pulse),
    .conv_done(conv_done), .conv_data(conv_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_ctrl(tx_ctrl), .tx_dest(tx_dest));
  adcp_far_model adcp_far_model_inst (.pclk(pclk), .presetn(presetn), .conv_req(conv_req),
    .conv_pin(conv_pin), .smp_base(smp_base), .hold_tx(hold_tx), .conv_done(conv_done),
    .conv_data(conv_data), .tx_ready(tx_ready));

  initial
  begin
    forever #20 pclk = ~pclk;
  end

  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    if (mismatches == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
    begin
      chk("pready wait", 0, 1);
      test_done();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    rq.push_back({1'b0, a > OFF_GEN, 32'h0});
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back({1'b1, a > OFF_GEN, x});
    apb(1'b0, a, 32'h0);
  endtask : rd

  function automatic logic [31:0] gv(input logic [1:0] w, input logic c, input logic en);
    return {14'h0, w, spp, 6'h0, c, en};
  endfunction : gv

  task automatic close(input int p);
    tq.push_back({1'b1, pin_reg[p][31:8], END_TOKEN});
    cnt[p] = 0;
  endtask : close

  task automatic trig(input int len);
    @(posedge pclk);
    smp_trig <= 1'b1;
    repeat (len) @(posedge pclk);
    smp_trig <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : trig

  task automatic settle();
    int n;
    n = 0;
    while ((tq.size() != 0 || conv_req !== 1'b0 || n < 8) && n < 2000)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2000)
    begin
      chk("output drained", 0, 1);
      test_done();
    end
  endtask : settle

  task automatic sample(input int len, input int hold);
    logic [SMP_W-1:0] b;
    logic [31:0] w;
    b = 12'($urandom);
    smp_base <= b;
    for (int p = 0; p < NPIN; p++)
    begin
      if (pin_reg[p][0])
      begin
        w = {b + 12'(13 * p), 20'h0};
        for (int k = 0; k <= int'(wid); k++)
          tq.push_back({1'b0, pin_reg[p][31:8], w[31 - 8 * k -: 8]});
        cnt[p]++;
        if (spp != 0 && cnt[p] == int'(spp))
          close(p);
      end
    end
    trig(len);
    repeat (hold) @(posedge pclk);
    hold_tx <= 1'b0;
    settle();
  endtask : sample

  task automatic en_cal();
    int c0;
    int v0;
    c0 = cal_seen;
    v0 = conv_seen;
    wr(OFF_GEN, gv(wid, 1'b0, 1'b1));
    repeat (6) trig(1);
    repeat (4) @(posedge pclk);
    chk("calibration pulses", 64'(cal_seen - c0), 6);
    chk("conversions in calibration", 64'(conv_seen - v0), 0);
    settle();
  endtask : en_cal

  always @(posedge pclk)
  begin
    if (presetn)
    begin
      if (cal_pulse === 1'b1)
        cal_seen++;
      if (conv_done === 1'b1)
        conv_seen++;
      if (pready === 1'b1)
      begin
        e = (rq.size() != 0) ? rq.pop_front() : 34'h3ffffffff;
        chk("pslverr", pslverr, e[32]);
        if (e[33])
          chk("prdata", prdata, e[31:0]);
      end
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
        chk("network byte", {tx_ctrl, tx_dest, tx_data},
          (tq.size() != 0) ? tq.pop_front() : 33'h1ffffffff);
    end
  end

  initial
  begin
    repeat (100000) @(posedge pclk);
    chk("watchdog", 0, 1);
    test_done();
  end

  initial
  begin
    seed_v = $urandom(32'h2228);
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < NPIN; i++)
      rd(OFF_PIN0 + 8'(4 * i), 32'h0);
    rd(OFF_GEN, 32'h01010100);
    rd(OFF_GEN, 32'h00010100);
    rd(8'h24, 32'h0);
    wr(8'h24, $urandom);
    mask = 8'($urandom) | 8'h81;
    // Enable is clear here, so pin setup is legal
    for (int i = 0; i < NPIN; i++)
    begin
      pin_reg[i] = {24'($urandom), 7'h0, mask[i]};
      cnt[i] = 0;
      wr(OFF_PIN0 + 8'(4 * i), pin_reg[i] | 32'hfe);
    end
    for (int i = 0; i < NPIN; i++)
      rd(OFF_PIN0 + 8'(4 * i), pin_reg[i]);
    en_cal();
    wr(OFF_PIN0, ~pin_reg[0]);
    rd(OFF_PIN0, pin_reg[0]);
    sample(1, 0);
    wid = WID_8;
    wr(OFF_GEN, gv(wid, 1'b0, 1'b1));
    sample(1, 0);
    wr(OFF_GEN, gv(WID_RSV, 1'b0, 1'b1));
    rd(OFF_GEN, gv(wid, 1'b0, 1'b1));
    wid = WID_32;
    wr(OFF_GEN, gv(wid, 1'b0, 1'b1));
    sample(1, 0);
    spp = 8'h02;
    wr(OFF_GEN, gv(wid, 1'b0, 1'b1));
    sample(1, 0);
    sample(1, 0);
    spp = 8'h00;
    wr(OFF_GEN, gv(wid, 1'b0, 1'b1));
    sample(1, 0);
    for (int p = 0; p < NPIN; p++)
      if (cnt[p] != 0)
        close(p);
    rd(OFF_GEN, gv(wid, 1'b0, 1'b1));
    settle();
    spp = 8'h01;
    wid = WID_16;
    wr(OFF_GEN, gv(wid, 1'b0, 1'b1));
    // Second trigger lands while the scanner is busy
    sample(2, 0);
    rd(OFF_GEN, gv(wid, 1'b0, 1'b1) | 32'h01000000);
    rd(OFF_GEN, gv(wid, 1'b0, 1'b1));
    wr(OFF_GEN, gv(wid, 1'b0, 1'b0));
    for (int i = 0; i < NPIN; i++)
    begin
      pin_reg[i][0] = 1'b1;
      wr(OFF_PIN0 + 8'(4 * i), pin_reg[i]);
    end
    en_cal();
    // Sink stalls long enough for the FIFO to fill and the scan to wait
    hold_tx <= 1'b1;
    sample(1, 80);
    // No sample is taken across the switch, so none needs discarding
    wr(OFF_GEN, gv(wid, 1'b1, 1'b1));
    repeat (2) @(posedge pclk);
    chk("reference select", conv_cal_sel, 1'b1);
    wr(OFF_GEN, gv(wid, 1'b0, 1'b1));
    repeat (2) @(posedge pclk);
    chk("reference select", conv_cal_sel, 1'b0);
    // Clock enable low freezes the block, so this trigger is never taken
    v_conv = conv_seen;
    ce <= 1'b0;
    trig(1);
    ce <= 1'b1;
    repeat (20) @(posedge pclk);
    chk("conversions while frozen", 64'(conv_seen - v_conv), 0);
    test_done();
  end
endmodule : adcp_ctrl_bench
